/* File: src/lts_pkg.sv */
package lts_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL_A = 8'h04;
  localparam logic [7:0] OFS_LEVEL_B = 8'h08;
  localparam logic [7:0] OFS_SLEW = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_DUTY = 8'h14;
  localparam logic [7:0] OFS_DROPOUT = 8'h18;
  localparam logic [7:0] OFS_RANGE_MAX = 8'h1C;
  localparam logic [7:0] OFS_SLEW_MAX = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_SETPOINT = 8'h28;
  localparam logic [7:0] OFS_TRANS_TIME = 8'h2C;
  localparam logic [7:0] OFS_CMD = 8'h30;

  // CTRL fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SLOW = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_EXT_TRIG = 7;

  // CMD bits (write-one pulses)
  localparam int CMD_SLOW_TOGGLE = 0;
  localparam int CMD_SLEW_DEFAULT = 1;

  // STATUS bits
  localparam int ST_SLOW = 0;
  localparam int ST_SLEW_WARN = 1;
  localparam int ST_LOW_BW = 2;
  localparam int ST_SLEW_ERR = 3;
  localparam int ST_DROPOUT = 4;
  localparam int ST_RUNNING = 5;
  localparam int ST_AT_B = 6;

  localparam int LEVEL_W = 24;
  localparam int DUTY_W = 7;

  // Reset values, limits and scale factors
  localparam logic [LEVEL_W-1:0] SLEW_CAL_DEFAULT = 24'h000100;
  localparam logic [LEVEL_W-1:0] SLEW_MAX_RESET = 24'h010000;
  localparam logic [LEVEL_W-1:0] SLEW_MIN = 24'h000001;
  localparam logic [LEVEL_W-1:0] RANGE_MAX_RESET = 24'hFFFFFF;
  localparam logic [31:0] PERIOD_RESET = 32'h000F4240;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 7'h32;
  localparam logic [DUTY_W-1:0] DUTY_MIN = 7'h01;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 7'h63;
  localparam logic [31:0] DUTY_SCALE = 32'h00000064;
  localparam logic [31:0] BW_DIV = 32'h000003E8;

  // Clock rate for time conversion
  localparam int CLK_HZ = 25_000_000;

  typedef enum logic [1:0] {
    constant_current_mode,
    constant_power_mode,
    constant_resistance_mode,
    constant_voltage_mode
  } load_mode_t;

  typedef enum logic [1:0] {
    SEL_LEVEL_A,
    SEL_LEVEL_B,
    SEL_TRANSIENT
  } level_sel_t;

endpackage

/* File: src/slew_if.sv */
`timescale 1ns/1ps
interface slew_if;
  logic [lts_pkg::LEVEL_W-1:0] target;
  logic [lts_pkg::LEVEL_W-1:0] step;
  logic [lts_pkg::LEVEL_W-1:0] preset_value;
  logic preset;
  logic [lts_pkg::LEVEL_W-1:0] value;
  logic at_target;
  modport ctrl (output target, output step, output preset_value, output preset,
    input value, input at_target);
  modport lim (input target, input step, input preset_value, input preset,
    output value, output at_target);
endinterface

/* File: src/slew_limiter.sv */
`timescale 1ns/1ps
module slew_limiter (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Control
  slew_if.lim s
);
  import lts_pkg::*;

  logic [LEVEL_W-1:0] cur;
  wire logic [LEVEL_W:0] up_sum = {1'b0, cur} + {1'b0, s.step};
  wire logic up_dir = s.target > cur;
  wire logic [LEVEL_W-1:0] gap = up_dir ? (s.target - cur) : (cur - s.target);
  // Clamp at target so the last step never overshoots
  wire logic [LEVEL_W-1:0] next_cur = (gap <= s.step) ? s.target :
    (up_dir ? up_sum[LEVEL_W-1:0] : cur - s.step);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= s.preset ? s.preset_value : next_cur;
    end
  end

  assign s.value = cur;
  assign s.at_target = (cur == s.target);
endmodule

/* File: src/load_level_transient_sequencer.sv */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Slow start ramps demand up from zero in current and power modes.
// - Ramp starts on enable or dropout crossing.
// - Disable with slow start ramps back to the rest value.
// - Toggle flips slow start; status shows it.
// - Resistance mode ramps from range maximum.
// - Voltage mode ramps from range maximum.
// - Transient alternates A and B, slewed.
// - Timing from oscillator or external trigger.
// - Oscillator cycle always starts at A.
// - Oscillator runs only when all conditions hold.
// - Fixed A or B ends transients.
// - Period and duty apply at A return.
// - Re-enable restarts a fresh cycle.
// - Duty is fraction spent at A.
// - Duty accepted only 1 to 99.
// - Setpoint changes go through limiter, except the jumps to rest when input stops with slow start off or starts with slow start on.
// - Default command restores calibrated slew.
// - Slew linear in the mode variable.
// - Report transition time as delta over slew.
// - Out-of-limit slew rejected with error flag.
// - Low bandwidth below slew maximum over 1000.
// - Warn when transition exceeds shorter phase.
// - Stop conducting below dropout except in voltage mode, non-latching.
module load_level_transient_sequencer (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Analogue side
  input wire logic [lts_pkg::LEVEL_W-1:0] i_source_v,
  input wire logic i_ext_trig,
  output logic [lts_pkg::LEVEL_W-1:0] o_demand,
  output logic o_conduct,
  output logic o_low_bw,
  output logic o_slow_active,
  output logic o_slew_warn
);
  import lts_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Configuration registers
  logic enable;
  logic slow_en;
  level_sel_t sel;
  load_mode_t mode;
  logic ext_sel;
  logic [LEVEL_W-1:0] level_a;
  logic [LEVEL_W-1:0] level_b;
  logic [LEVEL_W-1:0] slew;
  logic [LEVEL_W-1:0] slew_max;
  logic [LEVEL_W-1:0] range_max;
  logic [LEVEL_W-1:0] dropout;
  logic [31:0] period_pend;
  logic [DUTY_W-1:0] duty_pend;
  logic [31:0] period_act;
  logic [DUTY_W-1:0] duty_act;
  logic slew_err;

  // Sequencer state
  logic [31:0] cyc_cnt;
  logic osc_run;
  logic phase_b;
  logic enable_d;
  logic above_d;
  logic ramp_armed;
  logic [LEVEL_W-1:0] trans_time;

  // Trigger and source voltage comparison synchronisers
  logic [2:0] trig_sync;
  logic trig_state;
  logic [2:0] above_sync;
  logic above_state;

  wire logic wr_ctrl = i_wr && hit(i_addr, OFS_CTRL);
  wire logic wr_slew = i_wr && hit(i_addr, OFS_SLEW);
  wire logic wr_duty = i_wr && hit(i_addr, OFS_DUTY);
  wire logic wr_cmd = i_wr && hit(i_addr, OFS_CMD);
  wire logic slow_toggle = wr_cmd && i_wdata[CMD_SLOW_TOGGLE];
  wire logic slew_default = wr_cmd && i_wdata[CMD_SLEW_DEFAULT];
  wire logic [LEVEL_W-1:0] wslew = i_wdata[LEVEL_W-1:0];
  wire logic slew_ok = (wslew >= SLEW_MIN) && (wslew <= slew_max);
  wire logic [DUTY_W-1:0] wduty = i_wdata[DUTY_W-1:0];
  wire logic duty_ok = (i_wdata[31:DUTY_W] == '0) &&
    (wduty >= DUTY_MIN) && (wduty <= DUTY_MAX);

  // Comparator on a pin: counted only when last two stages agree
  wire logic src_above = i_source_v > dropout;
  wire logic above_next = (above_sync[2] == above_sync[1]) ? above_sync[2] : above_state;
  wire logic trig_next = (trig_sync[2] == trig_sync[1]) ? trig_sync[2] : trig_state;
  wire logic trig_rise = trig_next && !trig_state;
  wire logic trig_fall = !trig_next && trig_state;

  // Voltage mode has no dropout facility
  wire logic dropout_ok = above_state || (mode == constant_voltage_mode);
  wire logic input_on = enable && dropout_ok;
  wire logic enable_rise = enable && !enable_d;
  wire logic above_rise = above_state && !above_d;
  wire logic osc_cond = enable && (sel == SEL_TRANSIENT) && !ext_sel &&
    (!slow_en || dropout_ok);
  wire logic inverted = (mode == constant_resistance_mode) ||
    (mode == constant_voltage_mode);
  wire logic [LEVEL_W-1:0] rest_level = inverted ? range_max : '0;

  // Duty split of the active period
  wire logic [63:0] a_prod = {32'h0, period_act} * {57'h0, duty_act};
  wire logic [31:0] a_time = 32'(a_prod / {32'h0, DUTY_SCALE});
  wire logic [31:0] b_time = period_act - a_time;
  wire logic [31:0] short_time = (a_time < b_time) ? a_time : b_time;
  wire logic cyc_end = (cyc_cnt + 32'h1) >= period_act;

  wire logic [LEVEL_W-1:0] ab_gap = (level_a > level_b) ? (level_a - level_b) :
    (level_b - level_a);
  wire logic [LEVEL_W-1:0] step_safe = (slew == '0) ? SLEW_MIN : slew;
  wire logic [LEVEL_W-1:0] next_trans = ab_gap / step_safe;

  // Level selection feeding the limiter
  wire logic transient_b = ext_sel ? trig_state : phase_b;
  wire logic [LEVEL_W-1:0] run_level = (sel == SEL_LEVEL_A) ? level_a :
    (sel == SEL_LEVEL_B) ? level_b :
    (transient_b ? level_b : level_a);
  wire logic [LEVEL_W-1:0] tgt = input_on ? run_level : rest_level;
  // Slow start off: demand jumps straight to the rest value when the input stops
  wire logic hard_preset = !slow_en && !input_on;
  wire logic slow_preset = slow_en && ((enable_rise && !ramp_armed) || above_rise) &&
    input_on;

  slew_if sl ();
  assign sl.target = tgt;
  assign sl.step = step_safe;
  assign sl.preset = hard_preset || slow_preset;
  assign sl.preset_value = rest_level;

  slew_limiter u_slew (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .s(sl)
  );

  // Register writes
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable <= 1'b0;
      sel <= SEL_LEVEL_A;
      mode <= constant_current_mode;
      ext_sel <= 1'b0;
      level_a <= '0;
      level_b <= '0;
      dropout <= '0;
      range_max <= RANGE_MAX_RESET;
      slew_max <= SLEW_MAX_RESET;
      period_pend <= PERIOD_RESET;
    end else if (i_ce && i_wr) begin
      if (wr_ctrl) begin
        enable <= i_wdata[CTRL_ENABLE];
        sel <= level_sel_t'(i_wdata[CTRL_SEL_LSB +: 2]);
        mode <= load_mode_t'(i_wdata[CTRL_MODE_LSB +: 2]);
        ext_sel <= i_wdata[CTRL_EXT_TRIG];
      end
      if (hit(i_addr, OFS_LEVEL_A)) level_a <= i_wdata[LEVEL_W-1:0];
      if (hit(i_addr, OFS_LEVEL_B)) level_b <= i_wdata[LEVEL_W-1:0];
      if (hit(i_addr, OFS_DROPOUT)) dropout <= i_wdata[LEVEL_W-1:0];
      if (hit(i_addr, OFS_RANGE_MAX)) range_max <= i_wdata[LEVEL_W-1:0];
      if (hit(i_addr, OFS_SLEW_MAX)) slew_max <= i_wdata[LEVEL_W-1:0];
      if (hit(i_addr, OFS_PERIOD) && i_wdata != 32'h0) period_pend <= i_wdata;
    end
  end

  // Slew, duty and slow start control
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slew <= SLEW_CAL_DEFAULT;
      slew_err <= 1'b0;
      duty_pend <= DUTY_RESET;
      slow_en <= 1'b0;
    end else if (i_ce) begin
      if (slew_default) begin
        slew <= SLEW_CAL_DEFAULT;
      end else if (wr_slew && slew_ok) begin
        slew <= wslew;
      end
      // Error sticks until the next slew write or read of status
      if (wr_slew) begin
        slew_err <= !slew_ok;
      end else if (i_rd && hit(i_addr, OFS_STATUS)) begin
        slew_err <= 1'b0;
      end
      if (wr_duty && duty_ok) duty_pend <= wduty;
      if (slow_toggle) slow_en <= !slow_en;
    end
  end

  // Synchronisers for pin-level inputs
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_sync <= '0;
      trig_state <= 1'b0;
      above_sync <= '0;
      above_state <= 1'b0;
    end else if (i_ce) begin
      trig_sync <= {trig_sync[1:0], i_ext_trig};
      trig_state <= trig_next;
      above_sync <= {above_sync[1:0], src_above};
      above_state <= above_next;
    end
  end

  // Internal oscillator
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_cnt <= '0;
      osc_run <= 1'b0;
      phase_b <= 1'b0;
      period_act <= PERIOD_RESET;
      duty_act <= DUTY_RESET;
      enable_d <= 1'b0;
      above_d <= 1'b0;
      ramp_armed <= 1'b0;
    end else if (i_ce) begin
      enable_d <= enable;
      above_d <= above_state;
      ramp_armed <= enable;
      if (!osc_cond || enable_rise) begin
        // Restart at level A, with fresh timing
        osc_run <= osc_cond;
        cyc_cnt <= '0;
        phase_b <= 1'b0;
        period_act <= period_pend;
        duty_act <= duty_pend;
      end else if (cyc_end) begin
        cyc_cnt <= '0;
        phase_b <= 1'b0;
        period_act <= period_pend;
        duty_act <= duty_pend;
      end else begin
        cyc_cnt <= cyc_cnt + 32'h1;
        phase_b <= (cyc_cnt + 32'h1) >= a_time;
      end
    end
  end

  // Outputs and reported values
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_demand <= '0;
      o_conduct <= 1'b0;
      o_low_bw <= 1'b0;
      o_slow_active <= 1'b0;
      o_slew_warn <= 1'b0;
      trans_time <= '0;
    end else if (i_ce) begin
      o_demand <= sl.value;
      o_conduct <= input_on;
      o_low_bw <= ({40'h0, slew} * {32'h0, BW_DIV}) < {40'h0, slew_max};
      o_slow_active <= slow_en;
      trans_time <= next_trans;
      o_slew_warn <= ({8'h0, next_trans} > short_time);
    end
  end

  wire logic [31:0] status_word = {25'h0, phase_b, osc_run, !dropout_ok, slew_err,
    o_low_bw, o_slew_warn, o_slow_active};
  wire logic [31:0] ctrl_word = {24'h0, ext_sel, 1'b0, mode, sel, slow_en, enable};
  wire logic [31:0] rd_mux =
    hit(i_addr, OFS_CTRL) ? ctrl_word :
    hit(i_addr, OFS_LEVEL_A) ? {8'h0, level_a} :
    hit(i_addr, OFS_LEVEL_B) ? {8'h0, level_b} :
    hit(i_addr, OFS_SLEW) ? {8'h0, slew} :
    hit(i_addr, OFS_PERIOD) ? period_pend :
    hit(i_addr, OFS_DUTY) ? {25'h0, duty_pend} :
    hit(i_addr, OFS_DROPOUT) ? {8'h0, dropout} :
    hit(i_addr, OFS_RANGE_MAX) ? {8'h0, range_max} :
    hit(i_addr, OFS_SLEW_MAX) ? {8'h0, slew_max} :
    hit(i_addr, OFS_STATUS) ? status_word :
    hit(i_addr, OFS_SETPOINT) ? {8'h0, sl.value} :
    hit(i_addr, OFS_TRANS_TIME) ? {8'h0, trans_time} : 32'h0;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
    end
  end

endmodule

/* File: testbench/lts_props.sv */
`timescale 1ns/1ps
module lts_props (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Analogue side
  input wire logic [lts_pkg::LEVEL_W-1:0] i_source_v,
  input wire logic i_ext_trig,
  input wire logic [lts_pkg::LEVEL_W-1:0] o_demand,
  input wire logic o_conduct,
  input wire logic o_low_bw,
  input wire logic o_slow_active,
  input wire logic o_slew_warn
);
  import lts_pkg::*;
  // Shadows of what software wrote; slew max assumed left at reset
  logic [7:0] ctrl;
  logic [23:0] drop;
  logic [23:0] slew;
  wire tog = i_wr && i_addr == OFS_CMD && i_wdata[CMD_SLOW_TOGGLE];
  wire wr_ctrl = i_wr && i_addr == OFS_CTRL;
  wire wr_drop = i_wr && i_addr == OFS_DROPOUT;
  wire slew_ok = i_wdata >= 32'h1 && i_wdata <= {8'h00, SLEW_MAX_RESET};
  wire wr_slew = i_wr && i_addr == OFS_SLEW && slew_ok;
  wire slew_dflt = i_wr && i_addr == OFS_CMD && i_wdata[CMD_SLEW_DEFAULT];
  wire [23:0] next_slew = wr_slew ? i_wdata[23:0] : (slew_dflt ? SLEW_CAL_DEFAULT : slew);
  wire low_exp = {8'h00, slew} * 32'h3E8 < {8'h00, SLEW_MAX_RESET};
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= 8'h00;
      drop <= 24'h000000;
      slew <= SLEW_CAL_DEFAULT;
    end else begin
      ctrl <= wr_ctrl ? i_wdata[7:0] : ctrl;
      drop <= wr_drop ? i_wdata[23:0] : drop;
      slew <= next_slew;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_SLOW_CAUSE: assert property ($changed(o_slow_active) |-> $past(tog) || $past(tog, 2))
    else $error("slow indicator changed without toggle");
  AST_SLOW_FLIP: assert property (tog |=> ##1 o_slow_active != $past(o_slow_active, 2))
    else $error("slow toggle did not flip indicator");
  AST_OFF_DARK: assert property (!ctrl[CTRL_ENABLE] [*3] |-> !o_conduct)
    else $error("conducting while disabled");
  AST_DROP_STOP: assert property ((i_source_v < drop && ctrl[5:4] != 2'h3) [*8] |-> !o_conduct)
    else $error("conducting below dropout");
  AST_DROP_RESUME: assert property ((ctrl[CTRL_ENABLE] && i_source_v > drop) [*8] |-> o_conduct)
    else $error("no conduction above dropout");
  AST_LOW_BW: assert property ($stable(slew) [*4] |-> o_low_bw == low_exp)
    else $error("low bandwidth flag wrong");
  AST_IDLE_REST: assert property ((!ctrl[0] && !o_slow_active && ctrl[5:4] < 2'h2) [*4] |-> o_demand == 24'h0)
    else $error("demand not at rest when idle");
  AST_SLOW_STEP: assert property ((o_slow_active && ctrl[5:4] == 2'h0 && o_demand > $past(o_demand))
    |-> o_demand - $past(o_demand) <= (slew | $past(slew, 3)))
    else $error("slow start rise steeper than slew");
endmodule

bind load_level_transient_sequencer lts_props u_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_source_v(i_source_v),
  .i_ext_trig(i_ext_trig), .o_demand(o_demand), .o_conduct(o_conduct), .o_low_bw(o_low_bw),
  .o_slow_active(o_slow_active), .o_slew_warn(o_slew_warn)
);

/* File: testbench/source_model.sv */
`timescale 1ns/1ps
module source_model (
  // Bench side
  input wire logic [lts_pkg::LEVEL_W-1:0] i_open_v,
  // Load side
  input wire logic [lts_pkg::LEVEL_W-1:0] i_demand,
  input wire logic i_conduct,
  output logic [lts_pkg::LEVEL_W-1:0] o_v
);
  import lts_pkg::*;
  // Droop under load like a source with output resistance
  assign o_v = i_conduct ? i_open_v - (i_demand >> 8) : i_open_v;
endmodule

/* File: testbench/load_level_transient_sequencer_bench.sv */
`timescale 1ns/1ps
module load_level_transient_sequencer_bench;
  import lts_pkg::*;
  logic i_mclk, i_arst_n, i_wr, i_rd, i_ext_trig;
  logic o_conduct, o_low_bw, o_slow_active, o_slew_warn;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, seen;
  logic [LEVEL_W-1:0] i_source_v, o_demand, open_v, a, b, s;
  int n_errors = 0;
  int compares = 0;
  int k;
  int dv[4] = '{0, 1, 99, 100};
  int md[2] = '{2, 3};
  logic [31:0] bad[2] = '{32'h0, 32'h10001};
  logic [6:0] e;

  load_level_transient_sequencer u_dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_source_v(i_source_v),
    .i_ext_trig(i_ext_trig), .o_demand(o_demand), .o_conduct(o_conduct),
    .o_low_bw(o_low_bw), .o_slow_active(o_slow_active), .o_slew_warn(o_slew_warn));
  source_model u_src (.i_open_v(open_v), .i_demand(o_demand), .i_conduct(o_conduct),
    .o_v(i_source_v));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] cw(input logic en, input logic [1:0] sl, input logic [1:0] m,
    input logic ex);
    return {24'h0, ex, 1'b0, m, sl, 1'b0, en};
  endfunction
  function automatic logic [31:0] tt(input logic [23:0] x, input logic [23:0] y,
    input logic [23:0] r);
    return {8'h0, (x > y ? x - y : y - x) / r};
  endfunction

  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %h seen %h", n, ex, got);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge i_mclk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    seen = o_rdata;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] ex);
    rd(ad);
    chk($sformatf("reg %h", ad), ex, seen);
  endtask
  // Bounded wait, then demand must sit exactly on the target
  task automatic settle(input logic [23:0] t, input int lim);
    int c;
    c = 0;
    while (o_demand !== t && c < lim) begin
      @(negedge i_mclk);
      c++;
    end
    chk("demand", {8'h0, t}, {8'h0, o_demand});
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    n_errors++;
    close_out;
  end

  initial begin
    i_arst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ext_trig = 1'b0;
    open_v = 24'h008000;
    void'($urandom(32'h31177693));
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    rchk(OFS_SLEW, {8'h0, SLEW_CAL_DEFAULT});
    rchk(OFS_PERIOD, PERIOD_RESET);
    rchk(8'h3C, 32'h0);
    e = DUTY_RESET;
    foreach (dv[i]) begin
      wr(OFS_DUTY, dv[i]);
      if (dv[i] >= 1 && dv[i] <= 99) e = 7'(dv[i]);
      rchk(OFS_DUTY, {25'h0, e});
    end
    foreach (bad[i]) begin
      wr(OFS_SLEW, bad[i]);
      rd(OFS_STATUS);
      chk("slew error", 32'h1, {31'h0, seen[ST_SLEW_ERR]});
      rchk(OFS_SLEW, {8'h0, SLEW_CAL_DEFAULT});
    end
    wr(OFS_SLEW, 32'h20);
    wr(OFS_CMD, 32'h2);
    rchk(OFS_SLEW, {8'h0, SLEW_CAL_DEFAULT});
    repeat (4) begin
      a = 24'($urandom & 32'hFFFFF);
      b = 24'($urandom & 32'hFFFFF);
      s = 24'(1 + $urandom % 128);
      wr(OFS_LEVEL_A, {8'h0, a});
      wr(OFS_LEVEL_B, {8'h0, b});
      wr(OFS_SLEW, {8'h0, s});
      rchk(OFS_TRANS_TIME, tt(a, b, s));
      rd(OFS_STATUS);
      chk("low bw", {31'h0, 32'(s) * 32'h3E8 < 32'(SLEW_MAX_RESET)}, {31'h0, seen[ST_LOW_BW]});
    end
    $display("registers done");
    wr(OFS_LEVEL_A, 32'h1000);
    wr(OFS_LEVEL_B, 32'h200);
    wr(OFS_SLEW, 32'h100);
    wr(OFS_DROPOUT, 32'h100);
    wr(OFS_CTRL, cw(1, 0, 0, 0));
    pause(4);
    chk("ramp", 32'h1, {31'h0, o_demand < 24'h1000});
    settle(24'h1000, 40);
    wr(OFS_CTRL, cw(1, 1, 0, 0));
    settle(24'h200, 40);
    open_v = 24'h80;
    pause(12);
    chk("conduct low", 32'h0, {31'h0, o_conduct});
    open_v = 24'h8000;
    pause(12);
    chk("conduct back", 32'h1, {31'h0, o_conduct});
    $display("levels done");
    wr(OFS_SLEW, 32'h10);
    wr(OFS_CMD, 32'h1);
    rd(OFS_STATUS);
    chk("slow status", 32'h1, {31'h0, seen[ST_SLOW]});
    chk("slow pin", 32'h1, {31'h0, o_slow_active});
    wr(OFS_CTRL, cw(0, 1, 0, 0));
    pause(4);
    chk("slow stop", 32'h1, {31'h0, o_demand != 24'h0});
    settle(24'h0, 80);
    wr(OFS_CTRL, cw(1, 1, 0, 0));
    pause(4);
    chk("slow rise", 32'h1, {31'h0, o_demand < 24'h200});
    settle(24'h200, 80);
    wr(OFS_RANGE_MAX, 32'h3000);
    foreach (md[i]) begin
      wr(OFS_CTRL, cw(0, 0, 2'(md[i]), 0));
      settle(24'h3000, 1200);
      wr(OFS_CTRL, cw(1, 0, 2'(md[i]), 0));
      pause(4);
      chk("slow top", 32'h1, {31'h0, o_demand > 24'h1000});
      settle(24'h1000, 1200);
    end
    $display("slow start done");
    wr(OFS_CMD, 32'h1);
    wr(OFS_SLEW, 32'h100);
    wr(OFS_LEVEL_A, 32'h100);
    wr(OFS_LEVEL_B, 32'h900);
    wr(OFS_PERIOD, 32'd100);
    wr(OFS_DUTY, 32'd30);
    wr(OFS_CTRL, cw(1, 1, 0, 0));
    settle(24'h900, 300);
    wr(OFS_CTRL, cw(1, 2, 0, 0));
    settle(24'h100, 20);
    settle(24'h900, 100);
    settle(24'h100, 100);
    k = 0;
    repeat (100) begin
      @(negedge i_mclk);
      if (o_demand === 24'h900) k++;
    end
    // B share of the period, less the ramp steps, plus the limiter's one-cycle lag
    chk("time at B", 32'(100 - 100 * 30 / 100 - 32'h800 / 32'h100 + 1), k);
    chk("warn off", 32'h0, {31'h0, o_slew_warn});
    wr(OFS_SLEW, 32'h10);
    pause(6);
    chk("warn on", 32'h1, {31'h0, o_slew_warn});
    $display("transient done");
    wr(OFS_SLEW, 32'h100);
    wr(OFS_CTRL, cw(1, 2, 0, 1));
    i_ext_trig <= 1'b1;
    settle(24'h900, 40);
    wr(OFS_CTRL, cw(1, 0, 0, 1));
    settle(24'h100, 40);
    pause(20);
    chk("held A", 32'h100, {8'h0, o_demand});
    $display("external done");
    close_out;
  end
endmodule
